// File: logic/pulse_out_defs.vh
`ifndef PULSE_OUT_DEFS_VH
`define PULSE_OUT_DEFS_VH

// clock and timing
`define CLK_HZ 25'd25000000
`define MS_PER_S 25'd1000
`define CYC_PER_MS (`CLK_HZ / `MS_PER_S)
`define FREQ_MAX_HZ 14'd10000
`define PW_MIN_MS 8'd1

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_FBASE 8'h04
`define OFS_FSPAN 8'h08
`define OFS_VMIN 8'h0c
`define OFS_VMAX 8'h10
`define OFS_FSUBST 8'h14
`define OFS_UPP 8'h18
`define OFS_PWIDTH 8'h1c
`define OFS_CMD 8'h20
`define OFS_STATUS 8'h24
`define OFS_FREQ 8'h28

// control register fields
`define CTRL_EN 0
`define CTRL_TOT 1
`define CTRL_LINK 2
`define CTRL_POL 3
`define CTRL_ODRAIN 4
`define CTRL_ERR_LO 5
`define CTRL_ERR_HI 6
`define CTRL_W 7

// command register bits
`define CMD_ACCEPT 0
`define CMD_CANCEL 1

// error response codes
`define ERR_FORCE_LO 2'd0
`define ERR_FORCE_HI 2'd1
`define ERR_HOLD 2'd2
`define ERR_VALUE 2'd3

// reset values
`define RST_CTRL 7'h00
`define RST_FREQ 14'h0000
`define RST_VAL 16'h0000
`define RST_VMAX 16'hffff
`define RST_UPP 32'h00000001
`define RST_PW 8'h01

`endif

// File: logic/ratio_divider.v
`timescale 1ns/1ns
// restoring divider, one quotient bit per clock; 32 cycles from start to done
module ratio_divider
(
    // system
    input wire mclk,
    input wire rst_n,
    // request
    input wire start,
    input wire [31:0] numer,
    input wire [15:0] denom,
    // answer
    output reg busy,
    output reg done,
    output reg [31:0] quot
);

reg [5:0] count;
reg [16:0] rem;
reg [31:0] shift;
wire [16:0] trial;

assign trial = {rem[15:0], shift[31]} - {1'b0, denom};

always @(posedge mclk)
begin
    if (!rst_n)
    begin
        busy <= 1'b0;
        done <= 1'b0;
        quot <= 32'h00000000;
        count <= 6'h00;
        rem <= 17'h00000;
        shift <= 32'h00000000;
    end
    else
    begin
        done <= 1'b0;
        if (!busy)
        begin
            if (start)
            begin
                busy <= 1'b1;
                count <= 6'h20;
                rem <= 17'h00000;
                shift <= numer;
            end
        end
        else
        begin
            if (!trial[16])
                rem <= trial;
            else
                rem <= {rem[15:0], shift[31]};
            shift <= {shift[30:0], ~trial[16]};
            count <= count - 6'h01;
            if (count == 6'h01)
            begin
                busy <= 1'b0;
                done <= 1'b1;
                quot <= {shift[30:0], ~trial[16]};
            end
        end
    end
end

endmodule

// File: logic/freq_total_out.v
`timescale 1ns/1ns
`include "pulse_out_defs.vh"

module freq_total_out
(
    // system
    input wire mclk,
    input wire rst_n,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // measurement feed
    input wire param_valid,
    input wire [15:0] param_value,
    input wire qty_valid,
    input wire [15:0] qty_inc,
    input wire meter_error,
    input wire gate_open,
    // pulse pins, open drain capable
    output reg pulse_a,
    output reg pulse_a_oe_n,
    output reg pulse_b,
    output reg pulse_b_oe_n
);

localparam st_idle = 1'b0;
localparam st_div = 1'b1;

// staged settings, written by software
reg [6:0] stg_ctrl;
reg [13:0] stg_fbase;
reg [13:0] stg_fspan;
reg [15:0] stg_vmin;
reg [15:0] stg_vmax;
reg [13:0] stg_fsubst;
reg [31:0] stg_upp;
reg [7:0] stg_pw;
// active settings, used by the output logic
reg [6:0] ctrl;
reg [13:0] fbase;
reg [13:0] fspan;
reg [15:0] vmin;
reg [15:0] vmax;
reg [13:0] fsubst;
reg [31:0] upp;
reg [7:0] pw;

reg calc_state;
reg [13:0] good_freq;
reg [13:0] out_freq;
reg [24:0] phase;
reg [31:0] qty_acc;
reg [24:0] pw_cycles;
reg [25:0] tot_cnt;
reg tot_busy;
reg lost_pulse;

reg [31:0] next_rdata;
reg next_err;
reg [13:0] next_freq;
reg [24:0] next_phase;
reg [24:0] quad;
reg [32:0] next_acc;
reg fire;
reg lvl_a;
reg lvl_b;

wire bus_setup;
wire bus_write;
wire div_start;
wire div_busy;
wire div_done;
wire [31:0] div_quot;
wire [31:0] numer_full;
wire [15:0] span_v;
wire [13:0] span_f;
wire en;
wire tot_mode;
wire [1:0] err_sel;

function [13:0] clamp_freq;
    input [31:0] f;
    begin
        if (f > {18'h00000, `FREQ_MAX_HZ})
            clamp_freq = `FREQ_MAX_HZ;
        else
            clamp_freq = f[13:0];
    end
endfunction

assign bus_setup = psel & ~penable;
assign bus_write = psel & penable & pready & pwrite & ~pslverr;
assign en = ctrl[`CTRL_EN];
assign tot_mode = ctrl[`CTRL_TOT];
assign err_sel = ctrl[`CTRL_ERR_HI:`CTRL_ERR_LO];
assign span_v = vmax - vmin;
assign span_f = (fspan > fbase) ? fspan - fbase : 14'h0000;

// read mux and address decode
always @*
begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    case (paddr)
        `OFS_CTRL: next_rdata = {25'h0000000, stg_ctrl};
        `OFS_FBASE: next_rdata = {18'h00000, stg_fbase};
        `OFS_FSPAN: next_rdata = {18'h00000, stg_fspan};
        `OFS_VMIN: next_rdata = {16'h0000, stg_vmin};
        `OFS_VMAX: next_rdata = {16'h0000, stg_vmax};
        `OFS_FSUBST: next_rdata = {18'h00000, stg_fsubst};
        `OFS_UPP: next_rdata = stg_upp;
        `OFS_PWIDTH: next_rdata = {24'h000000, stg_pw};
        `OFS_CMD: next_rdata = 32'h00000000;
        `OFS_STATUS: next_rdata = {27'h0000000, lost_pulse, tot_busy,
                                   calc_state, meter_error, gate_open};
        `OFS_FREQ: next_rdata = {18'h00000, out_freq};
        default: next_err = 1'b1;
    endcase
end

// apb answers one cycle after setup: zero wait states
always @(posedge mclk)
begin
    if (!rst_n)
    begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
    end
    else
    begin
        pready <= bus_setup;
        pslverr <= bus_setup & next_err;
        if (bus_setup && !pwrite)
            prdata <= next_rdata;
    end
end

// staged and active register banks
always @(posedge mclk)
begin
    if (!rst_n)
    begin
        stg_ctrl <= `RST_CTRL;
        stg_fbase <= `RST_FREQ;
        stg_fspan <= `FREQ_MAX_HZ;
        stg_vmin <= `RST_VAL;
        stg_vmax <= `RST_VMAX;
        stg_fsubst <= `RST_FREQ;
        stg_upp <= `RST_UPP;
        stg_pw <= `RST_PW;
        ctrl <= `RST_CTRL;
        fbase <= `RST_FREQ;
        fspan <= `FREQ_MAX_HZ;
        vmin <= `RST_VAL;
        vmax <= `RST_VMAX;
        fsubst <= `RST_FREQ;
        upp <= `RST_UPP;
        pw <= `RST_PW;
    end
    else if (bus_write)
    begin
        case (paddr)
            `OFS_CTRL: stg_ctrl <= pwdata[`CTRL_W-1:0];
            // top of range held at the limit
            `OFS_FBASE: stg_fbase <= clamp_freq(pwdata);
            `OFS_FSPAN: stg_fspan <= clamp_freq(pwdata);
            `OFS_VMIN: stg_vmin <= pwdata[15:0];
            `OFS_VMAX: stg_vmax <= pwdata[15:0];
            `OFS_FSUBST: stg_fsubst <= clamp_freq(pwdata);
            `OFS_UPP: stg_upp <= pwdata;
            `OFS_PWIDTH: stg_pw <= (pwdata[7:0] < `PW_MIN_MS) ? `PW_MIN_MS : pwdata[7:0];
            `OFS_CMD:
            begin
                // accept copies all staged at once
                if (pwdata[`CMD_ACCEPT])
                begin
                    ctrl <= stg_ctrl;
                    fbase <= stg_fbase;
                    fspan <= stg_fspan;
                    vmin <= stg_vmin;
                    vmax <= stg_vmax;
                    fsubst <= stg_fsubst;
                    upp <= stg_upp;
                    pw <= stg_pw;
                end
                else if (pwdata[`CMD_CANCEL])
                begin
                    stg_ctrl <= ctrl;
                    stg_fbase <= fbase;
                    stg_fspan <= fspan;
                    stg_vmin <= vmin;
                    stg_vmax <= vmax;
                    stg_fsubst <= fsubst;
                    stg_upp <= upp;
                    stg_pw <= pw;
                end
            end
            default: stg_pw <= stg_pw;
        endcase
    end
end

// numerator (value - min) * frequency span
assign div_start = (calc_state == st_idle) && param_valid && !meter_error
                   && param_value > vmin && param_value < vmax;

// both factors widened first so the product cannot wrap
assign numer_full = {16'h0000, param_value - vmin} * {18'h00000, span_f};

ratio_divider u_div
(
    .mclk(mclk),
    .rst_n(rst_n),
    .start(div_start),
    .numer(numer_full),
    .denom(span_v),
    .busy(div_busy),
    .done(div_done),
    .quot(div_quot)
);

// last good frequency; samples arriving during a division are dropped
always @(posedge mclk)
begin
    if (!rst_n)
    begin
        calc_state <= st_idle;
        good_freq <= `RST_FREQ;
    end
    else
    begin
        case (calc_state)
            st_idle:
            begin
                // only error-free readings update the held value
                if (div_start)
                begin
                    calc_state <= st_div;
                end
                // ends of range map to base and span
                else if (param_valid && !meter_error && param_value <= vmin)
                    good_freq <= fbase;
                else if (param_valid && !meter_error)
                    good_freq <= fspan;
            end
            st_div:
            begin
                if (div_done)
                begin
                    good_freq <= clamp_freq(div_quot + {18'h00000, fbase});
                    calc_state <= st_idle;
                end
            end
            default: calc_state <= st_idle;
        endcase
    end
end

// frequency selection during errors
always @*
begin
    next_freq = good_freq;
    // error swaps in the chosen response
    if (meter_error)
    begin
        case (err_sel)
            `ERR_FORCE_LO: next_freq = fbase;
            `ERR_FORCE_HI: next_freq = fspan;
            `ERR_HOLD: next_freq = good_freq;
            `ERR_VALUE: next_freq = fsubst;
            default: next_freq = good_freq;
        endcase
    end
end

// phase accumulator wraps at the clock rate so the step equals hertz
always @*
begin
    next_phase = phase + {11'h000, out_freq};
    if (next_phase >= `CLK_HZ)
        next_phase = next_phase - `CLK_HZ;
    quad = phase + (`CLK_HZ >> 2);
    if (quad >= `CLK_HZ)
        quad = quad - `CLK_HZ;
end

// totalizer accumulation
always @*
begin
    next_acc = {1'b0, qty_acc};
    fire = 1'b0;
    // nothing accumulates while the gate is shorted
    if (qty_valid && gate_open)
        next_acc = {1'b0, qty_acc} + {17'h00000, qty_inc};
    if (upp != 32'h00000000 && next_acc >= {1'b0, upp})
    begin
        next_acc = next_acc - {1'b0, upp};
        fire = 1'b1;
    end
end

// output levels before drive mode; polarity applied in totalizer mode only
always @*
begin
    if (tot_mode)
    begin
        lvl_a = tot_busy && tot_cnt < {1'b0, pw_cycles};
        // pulse b starts half a width later
        lvl_b = tot_busy && tot_cnt >= {2'b00, pw_cycles[24:1]}
                && tot_cnt < {2'b00, pw_cycles[24:1]} + {1'b0, pw_cycles};
        if (ctrl[`CTRL_POL])
        begin
            lvl_a = ~lvl_a;
            lvl_b = ~lvl_b;
        end
    end
    else
    begin
        lvl_a = phase >= (`CLK_HZ >> 1);
        // quadrature copy of the same train
        lvl_b = quad >= (`CLK_HZ >> 1);
    end
    if (!en)
    begin
        lvl_a = 1'b0;
        lvl_b = 1'b0;
    end
    if (!ctrl[`CTRL_LINK])
        lvl_b = 1'b0;
end

always @(posedge mclk)
begin
    if (!rst_n)
    begin
        out_freq <= `RST_FREQ;
        phase <= 25'h0000000;
        qty_acc <= 32'h00000000;
        pw_cycles <= 25'h0000000;
        tot_cnt <= 26'h0000000;
        tot_busy <= 1'b0;
        lost_pulse <= 1'b0;
        pulse_a <= 1'b0;
        pulse_a_oe_n <= 1'b1;
        pulse_b <= 1'b0;
        pulse_b_oe_n <= 1'b1;
    end
    else
    begin
        out_freq <= (en && !tot_mode) ? next_freq : `RST_FREQ;
        phase <= (en && !tot_mode) ? next_phase : 25'h0000000;
        pw_cycles <= pw * `CYC_PER_MS;
        if (en && tot_mode)
            qty_acc <= next_acc[31:0];
        else
            qty_acc <= 32'h00000000;
        // period is twice the width, so at most 500 Hz at 1 ms
        if (tot_busy)
        begin
            if (tot_cnt >= {pw_cycles, 1'b0} - 26'h0000001)
                tot_busy <= 1'b0;
            tot_cnt <= tot_cnt + 26'h0000001;
        end
        // a pulse due while one runs is lost, flagged sticky
        if (en && tot_mode && fire)
        begin
            if (!tot_busy)
            begin
                tot_busy <= 1'b1;
                tot_cnt <= 26'h0000000;
            end
            else
                lost_pulse <= 1'b1;
        end
        else if (bus_write && paddr == `OFS_CMD && pwdata[`CMD_ACCEPT])
            lost_pulse <= 1'b0;
        pulse_a <= lvl_a;
        pulse_b <= lvl_b;
        // open drain releases the line for a high level
        pulse_a_oe_n <= ctrl[`CTRL_ODRAIN] & lvl_a;
        pulse_b_oe_n <= ctrl[`CTRL_ODRAIN] & lvl_b;
    end
end

endmodule

// File: bench/pulse_counter.sv
`timescale 1ns/1ns
// far-side tally: counts active edges on the wire and times the last pulse
module pulse_counter
(
    // wire side
    input wire mclk,
    input wire line,
    input wire active_low,
    // tallies
    output integer edges,
    output integer width
);
    integer run = 0;
    reg was = 1'b0;
    wire act = line ^ active_low;
    initial edges = 0;
    initial width = 0;
    always @(posedge mclk)
    begin
        was <= act;
        run <= act ? run + 1 : 0;
        if (act && !was)
            edges <= edges + 1;
        if (!act && was)
            width <= run;
    end
endmodule

// File: bench/freq_total_out_properties.sv
`timescale 1ns/1ns
module freq_total_out_checker
(
    // system
    input wire mclk,
    input wire rst_n,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // pins
    input wire pulse_a,
    input wire pulse_a_oe_n,
    input wire pulse_b
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    ready_answer_a: assert property (psel && !penable |=> pready) else $error("no ready");
    ready_single_a: assert property (pready |=> !pready) else $error("long ready");
    ready_access_a: assert property (pready |-> psel && penable) else $error("stray ready");
    err_ready_a: assert property (pslverr |-> pready) else $error("stray error");
    unmapped_err_a: assert property (psel && !penable && paddr > 8'h28 |=> pslverr)
        else $error("unmapped accepted");
    mapped_ok_a: assert property (psel && !penable && paddr <= 8'h28 && paddr[1:0] == 2'b00
        |=> !pslverr) else $error("mapped refused");
    cmd_zero_a: assert property (pready && !pwrite && paddr == 8'h20 |-> prdata == 32'h0)
        else $error("command reads nonzero");
    rdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved");
    freq_limit_a: assert property (pready && !pwrite && paddr inside {8'h04, 8'h08, 8'h14,
        8'h28} |-> prdata <= 32'd10000) else $error("frequency above limit");
    reset_idle_a: assert property (disable iff (1'b0) !rst_n |=> !pready && !pulse_a
        && pulse_a_oe_n && !pulse_b) else $error("outputs busy in reset");
    drain_release_a: assert property ($past(rst_n) && pulse_a_oe_n |-> pulse_a)
        else $error("released while low");
endmodule
bind freq_total_out freq_total_out_checker chk (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pulse_a(pulse_a), .pulse_a_oe_n(pulse_a_oe_n), .pulse_b(pulse_b));

// File: bench/testbench.sv
`timescale 1ns/1ns
`define CHK(g, x) begin checks_done++; if ((g) !== (x)) begin fails++; \
    $display("wrong value at %0t: got %h want %h", $time, (g), (x)); end end
module testbench;
    reg mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, low = 0;
    reg [7:0] paddr = 0;
    reg [31:0] pwdata = 0, q;
    reg param_valid = 0, qty_valid = 0, meter_error = 0, gate_open = 1, e;
    reg [15:0] param_value = 0, qty_inc = 0;
    wire [31:0] prdata;
    wire pready, pslverr, pulse_a, pulse_a_oe_n, pulse_b, pulse_b_oe_n;
    integer fails = 0, checks_done = 0, cycles = 0, edges, width, n0, i;
    integer want [4] = '{100, 10000, 5050, 1234};
    // pull-up on the wire when the output is released
    wire line_a = pulse_a_oe_n ? 1'b1 : pulse_a;
    always #20 mclk = ~mclk;
    freq_total_out uut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .param_valid(param_valid), .param_value(param_value),
        .qty_valid(qty_valid), .qty_inc(qty_inc), .meter_error(meter_error),
        .gate_open(gate_open), .pulse_a(pulse_a), .pulse_a_oe_n(pulse_a_oe_n),
        .pulse_b(pulse_b), .pulse_b_oe_n(pulse_b_oe_n));
    pulse_counter daq (.mclk(mclk), .line(line_a), .active_low(low), .edges(edges),
        .width(width));
    task stop_test;
        if (fails == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            fails = fails + 1;
            stop_test;
        end
    end
    task cyc(input integer n);
        repeat (n) @(posedge mclk);
    endtask
    // request held until pready is seen at a rising edge; one idle edge after release
    task apb(input [7:0] a, input w, input [31:0] d);
        begin
            psel <= 1'b1;
            penable <= 1'b0;
            paddr <= a;
            pwrite <= w;
            pwdata <= d;
            @(posedge mclk);
            penable <= 1'b1;
            @(posedge mclk);
            while (!pready)
                @(posedge mclk);
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge mclk);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        apb(a, 1'b1, d);
    endtask
    task rd(input [7:0] a, input [31:0] x);
        begin
            apb(a, 1'b0, 32'h0);
            `CHK(q, x)
        end
    endtask
    // 32-cycle divide plus two register stages, with margin
    task feed(input [15:0] v);
        begin
            param_value <= v;
            param_valid <= 1'b1;
            @(posedge mclk);
            param_valid <= 1'b0;
            cyc(40);
        end
    endtask
    task add(input [15:0] v);
        begin
            qty_inc <= v;
            qty_valid <= 1'b1;
            @(posedge mclk);
            qty_valid <= 1'b0;
            cyc(5);
        end
    endtask
    task t_regs;
        begin
            rd(8'h00, 32'h0);
            rd(8'h08, 32'h2710);
            rd(8'h10, 32'hffff);
            rd(8'h18, 32'h1);
            rd(8'h1c, 32'h1);
            rd(8'h20, 32'h0);
            apb(8'h2c, 1'b0, 32'h0);
            `CHK(e, 1'b1)
        end
    endtask
    task t_scale;
        begin
            wr(8'h04, 32'h0);
            wr(8'h08, 32'd20000);
            rd(8'h08, 32'd10000);
            wr(8'h10, 32'd1000);
            wr(8'h00, 32'h01);
            wr(8'h20, 32'h01);
            feed(500);
            rd(8'h28, 32'd5000);
            n0 = edges;
            cyc(10000);
            `CHK(edges - n0, 2)
            wr(8'h00, 32'h05);
            wr(8'h20, 32'h01);
            while (pulse_a)
                @(posedge mclk);
            while (!pulse_a)
                @(posedge mclk);
            `CHK(pulse_b, 1'b1)
            `CHK(pulse_b_oe_n, 1'b0)
            cyc(1240);
            `CHK(pulse_b, 1'b1)
            cyc(20);
            `CHK(pulse_b, 1'b0)
            feed(0);
            rd(8'h28, 32'h0);
            feed(2000);
            rd(8'h28, 32'd10000);
            wr(8'h04, 32'd100);
            wr(8'h20, 32'h02);
            rd(8'h04, 32'h0);
            rd(8'h28, 32'd10000);
        end
    endtask
    task t_err;
        begin
            wr(8'h04, 32'd100);
            wr(8'h14, 32'd1234);
            wr(8'h20, 32'h01);
            feed(500);
            rd(8'h28, 32'd5050);
            for (i = 0; i < 4; i++)
            begin
                wr(8'h00, 32'h01 | (i << 5));
                wr(8'h20, 32'h01);
                meter_error <= 1'b1;
                cyc(3);
                feed(900);
                rd(8'h28, want[i]);
                meter_error <= 1'b0;
                cyc(3);
            end
        end
    endtask
    task t_tot;
        begin
            wr(8'h18, 32'd3);
            wr(8'h1c, 32'd0);
            rd(8'h1c, 32'h1);
            wr(8'h00, 32'h1b);
            wr(8'h20, 32'h01);
            low <= 1'b1;
            cyc(5);
            `CHK(line_a, 1'b1)
            gate_open <= 1'b0;
            add(5);
            `CHK(line_a, 1'b1)
            gate_open <= 1'b1;
            add(2);
            `CHK(line_a, 1'b1)
            n0 = edges;
            add(1);
            `CHK(line_a, 1'b0)
            `CHK(pulse_b, 1'b0)
            cyc(25100);
            `CHK(width, 25000)
            `CHK(edges - n0, 1)
            rd(8'h24, 32'h9);
        end
    endtask
    initial
    begin
        cyc(5);
        rst_n <= 1'b1;
        cyc(1);
        t_regs;
        t_scale;
        t_err;
        t_tot;
        stop_test;
    end
endmodule
